// ### ecl_pkg.sv
// ==========================================================
// shared constants for the configuration loader
// ==========================================================
package ecl_pkg;

  // ========================================================
  // clock and timing
  // ========================================================
  localparam int CLK_PERIOD_NS   = 100;
  localparam int STRAP_NS        = 200;
  localparam int READ_START_NS   = 800;
  localparam int LOAD_WINDOW_MS  = 30;
  // least times round up to whole cycles
  localparam int STRAP_CYC       = (STRAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_START_CYC  = (READ_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_WINDOW_CYC = (LOAD_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
  localparam int SK_HALF_CYC     = 4;

  // ========================================================
  // serial memory framing
  // ========================================================
  localparam int        ADDR_BITS   = 8;
  localparam int        DATA_BITS   = 16;
  localparam int        CMD_BITS    = 3 + ADDR_BITS;
  localparam logic [3:0] RISE_HDR   = 4'hC;   // command rises plus dummy bit
  localparam logic [CMD_BITS-1:0] READ_FROM_ZERO = 11'h600;  // start, 10, addr 0
  localparam logic [1:0] OPC_WRITE  = 2'h1;
  localparam int        FRAME_BITS  = 2 + ADDR_BITS + DATA_BITS;
  localparam logic [ADDR_BITS-1:0] SIG_ADDR = 8'h00;

  // ========================================================
  // register map
  // ========================================================
  localparam logic [ADDR_BITS-1:0] ADDR_THRESH_HI = 8'h32;
  localparam logic [ADDR_BITS-1:0] ADDR_BW_EN     = 8'h33;
  localparam logic [7:0] THRESH_HI_RESET = 8'h00;
  localparam logic [8:0] BW_EN_RESET     = 9'h000;
  localparam int THR4_LSB = 0;
  localparam int LEN4_BIT = 3;
  localparam int THR5_LSB = 4;
  localparam int LEN5_BIT = 7;
  localparam int WRITE_THRESH_W = 8;    // bits 15:8 read-only
  localparam int WRITE_EN_W     = 9;    // bits 15:9 read-only

  // ========================================================
  // meter threshold codes to rate in kbit/s
  // ========================================================
  localparam logic [15:0] RATE_KBPS [8] = '{16'h0100, 16'h0200, 16'h03E8, 16'h07D0,
                                           16'h1388, 16'h2710, 16'h4E20, 16'hC350};
  localparam int BUDGET_SHIFT = 3;      // kbit/s over a 1 ms window in bytes

  // ========================================================
  // loader states, gray along the path
  // ========================================================
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_STRAP = 3'h1,
    ST_GAP   = 3'h3,
    ST_READ  = 3'h2,
    ST_HOLD  = 3'h6,
    ST_SNOOP = 3'h7
  } ecl_state_t;

endpackage

// ### ecl_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-flop synchroniser for pin levels
// ==========================================================
module ecl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // levels
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async;
      sync_q <= meta_q;
    end
  end

  assign synced = sync_q;

endmodule
`default_nettype wire

// ### ecl_port_meter.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// per-port ingress meter
// ==========================================================
module ecl_port_meter
  import ecl_pkg::*;
#(
  parameter int LEN_W = 11,
  parameter int CNT_W = 24
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // configuration
  input  wire logic [2:0]       threshCode,
  input  wire logic             lengthOff,
  input  wire logic             limitEn,
  // packet events
  input  wire logic             pktValid,
  input  wire logic [LEN_W-1:0] pktLen,
  input  wire logic             windowTick,
  // results
  output logic      [15:0]      rateKbps,
  output logic      [CNT_W-1:0] meterCount,
  output logic                  overLimit
);

  if (CNT_W <= 16 || LEN_W >= CNT_W) begin : g_chk
    $error("ecl_port_meter: counter too narrow");
  end

  logic [15:0]      rate_q, rate_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             over_q, over_d;

  // window restart wins, lengths add only while counting is on
  always_comb begin
    rate_d = RATE_KBPS[threshCode];
    cnt_d  = cnt_q;
    if (windowTick) begin
      cnt_d = '0;
    end else if (pktValid && !lengthOff) begin
      cnt_d = cnt_q + CNT_W'(pktLen);
    end
    // budget compare uses the previous rate; one cycle of lag is harmless
    over_d = limitEn && (cnt_q > CNT_W'(rate_q >> BUDGET_SHIFT));
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rate_q <= 16'h0000;
      cnt_q  <= '0;
      over_q <= 1'b0;
    end else begin
      rate_q <= rate_d;
      cnt_q  <= cnt_d;
      over_q <= over_d;
    end
  end

  assign rateKbps   = rate_q;
  assign meterCount = cnt_q;
  assign overLimit  = over_q;

endmodule
`default_nettype wire

// ### ecl_config_loader.sv
`timescale 1ns/1ps
`default_nettype none
module ecl_config_loader
  import ecl_pkg::*;
#(
  parameter int LOAD_WINDOW = LOAD_WINDOW_CYC,
  parameter int HALF_SK     = SK_HALF_CYC,
  parameter logic [DATA_BITS-1:0] SIGNATURE = 16'h5AA5,  // arbitrary value
  parameter int LEN_W       = 11,
  parameter int CNT_W       = 24
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // serial memory pins, enables active low
  input  wire logic             cfgMemSelectIn,
  output logic                  cfgMemSelectOut,
  output logic                  cfgMemSelectOeN,
  input  wire logic             cfgMemSerialClockIn,
  output logic                  cfgMemSerialClockOut,
  output logic                  cfgMemSerialClockOeN,
  input  wire logic             cfgMemDataInIn,
  output logic                  cfgMemDataInOut,
  output logic                  cfgMemDataInOeN,
  input  wire logic             cfgMemDataOutIn,
  output logic                  cfgMemDataOutOut,
  output logic                  cfgMemDataOutOeN,
  // packet events for ports four and five
  input  wire logic [1:0]       rxPktValid,
  input  wire logic [LEN_W-1:0] rxPktLen [2],
  input  wire logic             meterWindowTick,
  // configuration results
  output logic [5:0]            bwLimitEnable,
  output logic [15:0]           rateKbps [2],
  output logic [CNT_W-1:0]      meterCount [2],
  output logic [1:0]            overLimit,
  output logic [15:0]           threshHiReg,
  output logic [15:0]           bwEnableReg,
  // straps and load status
  output logic                  strapAutoMdix,
  output logic                  strapDualColour,
  output logic                  strapLoadEnable,
  output logic                  loadDone,
  output logic                  signatureOk
);

  if (HALF_SK < 3 || LOAD_WINDOW <= READ_START_CYC) begin : g_chk
    $error("ecl_config_loader: timing parameters out of range");
  end

  localparam int TMR_W = $clog2(LOAD_WINDOW + 1);
  localparam int DIV_W = $clog2(HALF_SK + 1);
  localparam logic [TMR_W-1:0] T_STRAP = TMR_W'(STRAP_CYC);
  localparam logic [TMR_W-1:0] T_READ  = TMR_W'(READ_START_CYC);
  localparam logic [TMR_W-1:0] T_HOLD  = TMR_W'(LOAD_WINDOW);
  localparam logic [DIV_W-1:0] D_LAST  = DIV_W'(HALF_SK - 1);

  // ========================================================
  // reset release and pin synchronisers
  // ========================================================
  logic [1:0] rstPipe_q;
  logic       rstN;
  logic [3:0] pinS;
  logic       csS, skS, diS, doS;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstN = rstPipe_q[1];

  ecl_sync #(.WIDTH(4)) u_pins (
    .clk    (mclk),
    .rstN   (rstN),
    .async  ({cfgMemSelectIn, cfgMemSerialClockIn, cfgMemDataInIn, cfgMemDataOutIn}),
    .synced (pinS)
  );
  assign {csS, skS, diS, doS} = pinS;

  // ========================================================
  // state
  // ========================================================
  ecl_state_t               state_q, state_d;
  logic [TMR_W-1:0]         tmr_q, tmr_d;
  logic [DIV_W-1:0]         div_q, div_d;
  logic                     csOut_q, csOut_d;
  logic                     skOut_q, skOut_d;
  logic                     diOut_q, diOut_d;
  logic                     drive_q, drive_d;
  logic [CMD_BITS-1:0]      cmdSr_q, cmdSr_d;
  logic [3:0]               rise_q, rise_d;
  logic [3:0]               bit_q, bit_d;
  logic [ADDR_BITS-1:0]     word_q, word_d;
  logic [DATA_BITS-1:0]     shift_q, shift_d;
  logic [DATA_BITS-1:0]     wordIn;
  logic                     sigOk_q, sigOk_d;
  logic                     done_q, done_d;
  logic [2:0]               strap_q, strap_d;
  logic [7:0]               thresh_q, thresh_d;
  logic [8:0]               bwEn_q, bwEn_d;
  logic                     skPrev_q;
  logic                     skRise;
  logic                     snStart_q, snStart_d;
  logic [4:0]               snCnt_q, snCnt_d;
  logic [FRAME_BITS-1:0]    snSr_q, snSr_d;
  logic                     snPend_q, snPend_d;
  logic                     wrEn;
  logic [ADDR_BITS-1:0]     wrAddr;
  logic [DATA_BITS-1:0]     wrData;

  assign skRise = skS && !skPrev_q;
  assign wordIn = {shift_q[DATA_BITS-2:0], doS};

  // ========================================================
  // loader sequence and memory reader
  // ========================================================
  always_comb begin
    state_d = state_q;
    tmr_d   = (tmr_q == T_HOLD) ? tmr_q : tmr_q + 1'b1;
    div_d   = div_q;
    csOut_d = csOut_q;
    skOut_d = skOut_q;
    diOut_d = diOut_q;
    drive_d = drive_q;
    cmdSr_d = cmdSr_q;
    rise_d  = rise_q;
    bit_d   = bit_q;
    word_d  = word_q;
    shift_d = shift_q;
    sigOk_d = sigOk_q;
    done_d  = done_q;
    strap_d = strap_q;
    wrEn    = 1'b0;
    wrAddr  = word_q;
    wrData  = wordIn;
    case (state_q)
      ST_RESET: begin
        state_d = ST_STRAP;
      end
      ST_STRAP: begin
        // pins have settled through the synchroniser by now
        if (tmr_q >= T_STRAP) begin
          strap_d = {skS, diS, doS};
          state_d = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tmr_q >= T_READ) begin
          if (strap_q[0]) begin
            state_d = ST_READ;
            drive_d = 1'b1;
            csOut_d = 1'b1;
            skOut_d = 1'b0;
            diOut_d = READ_FROM_ZERO[CMD_BITS-1];
            cmdSr_d = READ_FROM_ZERO;
            div_d   = '0;
          end else begin
            state_d = ST_HOLD;
          end
        end
      end
      ST_READ: begin
        div_d = div_q + 1'b1;
        if (div_q == D_LAST) begin
          div_d = '0;
          if (!skOut_q) begin
            skOut_d = 1'b1;
            cmdSr_d = cmdSr_q << 1;
            if (rise_q != RISE_HDR) begin
              rise_d = rise_q + 1'b1;
            end else begin
              // data bit was presented after the previous fall
              shift_d = wordIn;
              bit_d   = bit_q + 1'b1;
              if (bit_q == 4'hF) begin
                word_d = word_q + 1'b1;
                if (word_q == SIG_ADDR) begin
                  sigOk_d = (wordIn == SIGNATURE);
                  if (wordIn != SIGNATURE) begin
                    state_d = ST_HOLD;
                  end
                end else begin
                  wrEn = 1'b1;
                  if (word_q == ADDR_BW_EN) begin
                    state_d = ST_HOLD;
                  end
                end
              end
            end
          end else begin
            skOut_d = 1'b0;
            diOut_d = cmdSr_q[CMD_BITS-1];
          end
        end
        if (state_d == ST_HOLD) begin
          csOut_d = 1'b0;
          skOut_d = 1'b0;
          diOut_d = 1'b0;
          drive_d = 1'b0;
        end
      end
      ST_HOLD: begin
        // host must leave the pins alone until the window ends
        if (tmr_q == T_HOLD) begin
          state_d = ST_SNOOP;
          done_d  = 1'b1;
        end
      end
      ST_SNOOP: begin
        wrEn   = snPend_q && !csS && skRise;
        wrAddr = snSr_q[DATA_BITS +: ADDR_BITS];
        wrData = snSr_q[DATA_BITS-1:0];
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  // ========================================================
  // host write snooper
  // ========================================================
  always_comb begin
    snStart_d = snStart_q;
    snCnt_d   = snCnt_q;
    snSr_d    = snSr_q;
    snPend_d  = snPend_q;
    if (state_q == ST_SNOOP) begin
      if (!csS) begin
        snStart_d = 1'b0;
        snCnt_d   = 5'h00;
        if (skRise) begin
          snPend_d = 1'b0;
        end
      end else if (skRise) begin
        if (!snStart_q) begin
          snStart_d = diS;
          snPend_d  = 1'b0;
        end else if (snCnt_q != 5'(FRAME_BITS)) begin
          snSr_d  = {snSr_q[FRAME_BITS-2:0], diS};
          snCnt_d = snCnt_q + 1'b1;
          // opcode lands in the top two bits on the last shift
          snPend_d = (snCnt_q == 5'(FRAME_BITS - 1)) &&
                     (snSr_q[FRAME_BITS-2 -: 2] == OPC_WRITE);
        end else begin
          snPend_d = 1'b0;                                         // overlong frame dropped
        end
      end
    end
  end

  // ========================================================
  // configuration registers
  // ========================================================
  always_comb begin
    thresh_d = thresh_q;
    bwEn_d   = bwEn_q;
    if (wrEn && wrAddr == ADDR_THRESH_HI) begin
      thresh_d = wrData[WRITE_THRESH_W-1:0];
    end
    if (wrEn && wrAddr == ADDR_BW_EN) begin
      bwEn_d = wrData[WRITE_EN_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_q   <= ST_RESET;
      tmr_q     <= '0;
      div_q     <= '0;
      csOut_q   <= 1'b0;
      skOut_q   <= 1'b0;
      diOut_q   <= 1'b0;
      drive_q   <= 1'b0;
      cmdSr_q   <= '0;
      rise_q    <= 4'h0;
      bit_q     <= 4'h0;
      word_q    <= SIG_ADDR;
      shift_q   <= '0;
      sigOk_q   <= 1'b0;
      done_q    <= 1'b0;
      strap_q   <= 3'h1;        // unstrapped: no crossover, single colour, load on
      thresh_q  <= THRESH_HI_RESET;
      bwEn_q    <= BW_EN_RESET;
      skPrev_q  <= 1'b0;
      snStart_q <= 1'b0;
      snCnt_q   <= 5'h00;
      snSr_q    <= '0;
      snPend_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      tmr_q     <= tmr_d;
      div_q     <= div_d;
      csOut_q   <= csOut_d;
      skOut_q   <= skOut_d;
      diOut_q   <= diOut_d;
      drive_q   <= drive_d;
      cmdSr_q   <= cmdSr_d;
      rise_q    <= rise_d;
      bit_q     <= bit_d;
      word_q    <= word_d;
      shift_q   <= shift_d;
      sigOk_q   <= sigOk_d;
      done_q    <= done_d;
      strap_q   <= strap_d;
      thresh_q  <= thresh_d;
      bwEn_q    <= bwEn_d;
      skPrev_q  <= skS;
      snStart_q <= snStart_d;
      snCnt_q   <= snCnt_d;
      snSr_q    <= snSr_d;
      snPend_q  <= snPend_d;
    end
  end

  // ========================================================
  // ingress meters for ports four and five
  // ========================================================
  for (genvar p = 0; p < 2; p++) begin : g_meter
    ecl_port_meter #(.LEN_W(LEN_W), .CNT_W(CNT_W)) u_meter (
      .clk        (mclk),
      .rstN       (rstN),
      .threshCode (thresh_q[(p == 0 ? THR4_LSB : THR5_LSB) +: 3]),
      .lengthOff  (thresh_q[p == 0 ? LEN4_BIT : LEN5_BIT]),
      .limitEn    (bwEn_q[7 + p]),
      .pktValid   (rxPktValid[p]),
      .pktLen     (rxPktLen[p]),
      .windowTick (meterWindowTick),
      .rateKbps   (rateKbps[p]),
      .meterCount (meterCount[p]),
      .overLimit  (overLimit[p])
    );
  end

  // ========================================================
  // outputs, all straight from flops
  // ========================================================
  assign cfgMemSelectOut      = csOut_q;
  assign cfgMemSelectOeN      = !drive_q;
  assign cfgMemSerialClockOut = skOut_q;
  assign cfgMemSerialClockOeN = !drive_q;
  assign cfgMemDataInOut      = diOut_q;
  assign cfgMemDataInOeN      = !drive_q;
  assign cfgMemDataOutOut     = rstPipe_q[0] & 1'b0;
  assign cfgMemDataOutOeN     = rstPipe_q[1] | 1'b1;  // never driven
  assign bwLimitEnable = {bwEn_q[8], bwEn_q[7], bwEn_q[6], bwEn_q[4], bwEn_q[2], bwEn_q[0]};
  assign threshHiReg   = {8'h00, thresh_q};
  assign bwEnableReg   = {7'h00, bwEn_q};
  assign strapAutoMdix   = strap_q[2];
  assign strapDualColour = strap_q[1];
  assign strapLoadEnable = strap_q[0];
  assign loadDone        = done_q;
  assign signatureOk     = sigOk_q;

endmodule
`default_nettype wire

// ### ecl_config_loader_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// pin and register checks
module ecl_config_loader_chk
  import ecl_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // memory pins
  input wire logic        cfgMemSelectOeN,
  input wire logic        cfgMemSerialClockOut,
  input wire logic        cfgMemDataOutOeN,
  // configuration results
  input wire logic [5:0]  bwLimitEnable,
  input wire logic [15:0] rateKbps [2],
  input wire logic [15:0] threshHiReg,
  input wire logic [15:0] bwEnableReg,
  input wire logic        loadDone,
  input wire logic        signatureOk
);
  logic [2:0] upCnt_q;
  logic [2:0] upCnt_d;

  // settle count, since the internal reset lags two flops
  always_comb upCnt_d = (upCnt_q == 3'h7) ? upCnt_q : upCnt_q + 3'h1;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) upCnt_q <= 3'h0;
    else upCnt_q <= upCnt_d;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_do_input: assert property (cfgMemDataOutOeN)
    else $error("data-out pin driven");
  chk_drive_window: assert property (!cfgMemSelectOeN |-> !loadDone)
    else $error("select driven after load window");
  chk_thresh_ro: assert property (threshHiReg[15:8] == 8'h00)
    else $error("threshold upper byte not zero");
  chk_enable_ro: assert property (bwEnableReg[15:9] == 7'h00)
    else $error("enable upper bits not zero");
  chk_enable_map: assert property ($stable(bwEnableReg) && upCnt_q == 3'h7 |->
    bwLimitEnable == {bwEnableReg[8:6], bwEnableReg[4], bwEnableReg[2], bwEnableReg[0]})
    else $error("enable bits misplaced");
  chk_rate_map: assert property ($stable(threshHiReg) && upCnt_q == 3'h7 |->
    rateKbps[0] == RATE_KBPS[threshHiReg[2:0]] && rateKbps[1] == RATE_KBPS[threshHiReg[6:4]])
    else $error("rate does not follow code");
  chk_skip_defaults: assert property ($rose(loadDone) && !signatureOk |->
    threshHiReg == 16'h0000 && bwEnableReg == 16'h0000)
    else $error("registers changed by skipped load");
  chk_sk_low: assert property ($fell(cfgMemSerialClockOut) |-> (!cfgMemSerialClockOut) [*4])
    else $error("serial clock low half too short");
endmodule

bind ecl_config_loader ecl_config_loader_chk i_ecl_config_loader_chk (.mclk(mclk), .arst_n(arst_n),
  .cfgMemSelectOeN(cfgMemSelectOeN), .cfgMemSerialClockOut(cfgMemSerialClockOut),
  .cfgMemDataOutOeN(cfgMemDataOutOeN), .bwLimitEnable(bwLimitEnable), .rateKbps(rateKbps),
  .threshHiReg(threshHiReg), .bwEnableReg(bwEnableReg), .loadDone(loadDone), .signatureOk(signatureOk));
`default_nettype wire

// ### ecl_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// serial memory answering sequential reads
module ecl_mem_model (
  // memory pins as seen on the board
  input  wire logic        sel,
  input  wire logic        sck,
  input  wire logic        sdi,
  // words held at 0, 0x32 and 0x33
  input  wire logic [15:0] sigWord,
  input  wire logic [15:0] thrWord,
  input  wire logic [15:0] enWord,
  // data-out pin, enable high while driving
  output logic             doOe,
  output logic             doVal
);
  int          rises = 0;
  int          k;
  logic [2:0]  cmd = 3'h0;
  logic [15:0] w;

  initial doOe = 1'b0;

  // rises counted per select frame; opcode caught so writes never drive
  always @(posedge sck or negedge sel) begin
    if (!sel) rises <= 0;
    else begin
      rises <= rises + 1;
      if (rises < 3) cmd <= {cmd[1:0], sdi};
    end
  end

  // next data bit after each fall once twelve header rises are
  always @(negedge sck or negedge sel) begin
    k = rises - 12;
    w = (k < 16) ? sigWord : (k / 16 == 50) ? thrWord : (k / 16 == 51) ? enWord : 16'(k / 16) ^ 16'hA5C3;
    doOe <= sel && cmd == 3'h6 && k >= 0;
    doVal <= (k >= 0) ? w[15 - k % 16] : 1'b0;
  end
endmodule
`default_nettype wire

// ### ecl_config_loader_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// bench: load, snoop and meter scenarios
module ecl_config_loader_bench
  import ecl_pkg::*;
();
  localparam logic [15:0] SIG = 16'h3CC3;  // arbitrary signature
  typedef struct { int id; logic [15:0] v; } ecl_note_t;
  logic        mclk, arst_n, tickW, hSel, hSk, hDi, hDo, mOe, mDo;
  logic [3:0]  hEn;  // host drives: select, clock, data-in, data-out
  logic [1:0]  pv, over;
  logic [10:0] pl [2];
  logic [15:0] sigW, thrW, enW, thrE, d;
  logic        selOut, selOeN, skOut, skOeN, diOut, diOeN, sMdix, sDual, sLoad, done, sigOk;
  logic        selW, skW, diW, doW;
  logic [5:0]  bwEn;
  logic [15:0] rate [2];
  logic [15:0] thr, en;
  logic [23:0] cnt [2];
  logic [1:0]  ops [3] = '{2'h0, 2'h2, 2'h3};
  ecl_note_t   q [$];
  ecl_note_t   nt;
  int          fail_count, n_tests, seed, len;
  string       nm [10] = '{"thr", "en", "limit", "rate4", "rate5", "count4", "over4", "straps", "status", "count5"};

  // pins: pull-downs on select, clock, data-in; pull-up on data-out
  assign selW = !selOeN ? selOut : (hEn[0] ? hSel : 1'b0);
  assign skW  = !skOeN ? skOut : (hEn[1] ? hSk : 1'b0);
  assign diW  = !diOeN ? diOut : (hEn[2] ? hDi : 1'b0);
  assign doW  = mOe ? mDo : (hEn[3] ? hDo : 1'b1);

  ecl_config_loader #(.LOAD_WINDOW(8000), .SIGNATURE(SIG)) i_ecl_config_loader (.mclk(mclk), .arst_n(arst_n),
    .cfgMemSelectIn(selW), .cfgMemSelectOut(selOut), .cfgMemSelectOeN(selOeN),
    .cfgMemSerialClockIn(skW), .cfgMemSerialClockOut(skOut), .cfgMemSerialClockOeN(skOeN),
    .cfgMemDataInIn(diW), .cfgMemDataInOut(diOut), .cfgMemDataInOeN(diOeN),
    .cfgMemDataOutIn(doW), .cfgMemDataOutOut(), .cfgMemDataOutOeN(),
    .rxPktValid(pv), .rxPktLen(pl), .meterWindowTick(tickW), .bwLimitEnable(bwEn), .rateKbps(rate),
    .meterCount(cnt), .overLimit(over), .threshHiReg(thr), .bwEnableReg(en), .strapAutoMdix(sMdix),
    .strapDualColour(sDual), .strapLoadEnable(sLoad), .loadDone(done), .signatureOk(sigOk));

  ecl_mem_model i_ecl_mem_model (.sel(selW), .sck(skW), .sdi(diW), .sigWord(sigW), .thrWord(thrW),
    .enWord(enW), .doOe(mOe), .doVal(mDo));

  // ========================================
  // notes and comparison
  function automatic logic [15:0] seen(int id);
    logic [15:0] s [10];
    s = '{thr, en, {10'h000, bwEn}, rate[0], rate[1], cnt[0][15:0], {15'h0000, over[0]},
          {13'h0000, sMdix, sDual, sLoad}, {14'h0000, done, sigOk}, cnt[1][15:0]};
    return s[id];
  endfunction

  function automatic logic [15:0] emap(logic [15:0] e);
    return {10'h000, e[8:6], e[4], e[2], e[0]};
  endfunction

  task automatic note(int id, logic [15:0] v);
    q.push_back('{id, v});
  endtask

  task automatic check(string name, logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // compare at the falling edge, when outputs have settled
  always @(negedge mclk) begin
    while (q.size() > 0) begin
      nt = q.pop_front();
      check(nm[nt.id], seen(nt.id), nt.v);
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ========================================
  // drivers
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask

  // straps held past the sample point, then released in the advised order
  task automatic doReset(logic sk, logic di, logic dout);
    @(posedge mclk);
    arst_n <= 1'b0;
    hEn <= 4'hF;
    {hSel, hSk, hDi, hDo} <= {1'b0, sk, di, dout};
    tick(12);
    arst_n <= 1'b1;
    tick(4);
    hEn <= 4'hE;
    tick(1);
    hEn <= 4'hA;
    tick(1);
    hEn <= 4'h2;
    tick(1);
    hEn <= 4'h0;
    for (int i = 0; i < 9000 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) begin
      fail_count++;
      final_report();
    end
  endtask

  // one instruction per select, then the extra clock after select falls
  task automatic hostWrite(logic [1:0] opc, logic [7:0] adr, logic [15:0] dat);
    logic [26:0] f;
    f = {1'b1, opc, adr, dat};
    @(posedge mclk);
    hEn <= 4'h7;
    hSel <= 1'b1;
    hSk <= 1'b0;
    for (int i = 26; i >= 0; i--) begin
      tick(4);
      hSk <= 1'b0;
      hDi <= f[i];
      tick(4);
      hSk <= 1'b1;
    end
    tick(4);
    hSk <= 1'b0;
    tick(4);
    hSel <= 1'b0;
    tick(4);
    hSk <= 1'b1;
    tick(4);
    hSk <= 1'b0;
    tick(4);
    hEn <= 4'h0;
  endtask

  task automatic pkt(logic [10:0] n);
    @(posedge mclk);
    tickW <= 1'b1;
    @(posedge mclk);
    tickW <= 1'b0;
    pv <= 2'h3;
    pl[0] <= n;
    pl[1] <= ~n;
    @(posedge mclk);
    pv <= 2'h0;
    tick(3);
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ========================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    hEn = 4'hF;
    {hSel, hSk, hDi, hDo} = 4'h1;
    {pv, tickW} = 3'h0;
    pl = '{11'h000, 11'h000};
    {fail_count, n_tests} = 0;
    seed = 32'h2022;
    sigW = SIG;
    thrW = 16'($random(seed));
    enW = 16'($random(seed));
    doReset(1'b1, 1'b1, 1'b1);
    note(7, 16'h0007);
    note(8, 16'h0003);
    note(0, {8'h00, thrW[7:0]});
    note(1, {7'h00, enW[8:0]});
    note(2, emap(enW));
    // every threshold code on both ports, upper byte random
    for (int c = 0; c < 8; c++) begin
      d = 16'($random(seed));
      d[2:0] = c[2:0];
      d[6:4] = 3'h7 - c[2:0];
      hostWrite(2'h1, ADDR_THRESH_HI, d);
      thrE = {8'h00, d[7:0]};
      note(0, thrE);
      note(3, RATE_KBPS[c]);
      note(4, RATE_KBPS[7 - c]);
    end
    // other opcodes and an unmapped address leave the registers alone
    for (int o = 0; o < 4; o++) begin
      d = 16'($random(seed));
      hostWrite((o < 3) ? ops[o] : 2'h1, (o < 3) ? ADDR_THRESH_HI : 8'h31, d);
      note(0, thrE);
    end
    d = 16'($random(seed));
    hostWrite(2'h1, ADDR_BW_EN, d);
    note(1, {7'h00, d[8:0]});
    note(2, emap(d));
    // meter at 256K: budget 32 bytes per window
    len = 33 + ($random(seed) & 1023);
    hostWrite(2'h1, ADDR_THRESH_HI, 16'h0000);
    hostWrite(2'h1, ADDR_BW_EN, 16'h0080);
    pkt(len[10:0]);
    note(5, len[15:0]);
    note(9, {5'h00, ~len[10:0]});
    note(6, 16'h0001);
    hostWrite(2'h1, ADDR_THRESH_HI, 16'h0008);
    pkt(len[10:0]);
    note(5, 16'h0000);
    note(9, {5'h00, ~len[10:0]});
    hostWrite(2'h1, ADDR_THRESH_HI, 16'h0000);
    hostWrite(2'h1, ADDR_BW_EN, 16'h0000);
    pkt(len[10:0]);
    note(6, 16'h0000);
    // bad signature with default straps, then loading strapped off
    sigW = ~SIG;
    doReset(1'b0, 1'b0, 1'b1);
    note(7, 16'h0001);
    note(8, 16'h0002);
    note(0, 16'h0000);
    note(1, 16'h0000);
    doReset(1'b1, 1'b0, 1'b0);
    note(7, 16'h0004);
    note(8, 16'h0002);
    note(0, 16'h0000);
    d = 16'($random(seed));
    hostWrite(2'h1, ADDR_BW_EN, d);
    note(1, {7'h00, d[8:0]});
    tick(2);
    final_report();
  end
endmodule
`default_nettype wire
